// ==== core/sram_host_ctrl.sv ====
`timescale 1ns/1ps
module sram_host_ctrl
  import sram_ctrl_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_CYC
)
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // User request
  input  wire logic              i_req_valid,
  input  wire req_s              i_req,
  output logic                   o_req_ready,
  // Read answer
  output logic                   o_rsp_valid,
  output logic      [DATA_W-1:0] o_rsp_data,
  // Status
  output logic                   o_init_done,
  // Memory control pins
  output pins_s                  o_pins,
  // Shared data bus
  input  wire logic [DATA_W-1:0] i_data_in,
  output logic      [DATA_W-1:0] o_data_out,
  output logic                   o_data_oe
);

  // ==========================================================================
  // State
  state_e            state_ff;
  state_e            nxt_state;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  nxt_cnt;
  pins_s             pins_ff;
  pins_s             nxt_pins;
  logic [DATA_W-1:0] dout_ff;
  logic [DATA_W-1:0] nxt_dout;
  logic              doe_ff;
  logic              nxt_doe;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic              rvalid_ff;
  logic              nxt_rvalid;
  logic              init_ff;
  logic              nxt_init;
  logic [DATA_W-1:0] data_sync;
  logic              take;

  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(POWER_UP_CYCLES - 1);

  // ==========================================================================
  // Data pin capture
  sram_data_sync u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_data_in),
    .o_sync    (data_sync)
  );

  // New work is taken only between accesses, after the power-up wait
  assign take = i_req_valid && (state_ff == ST_IDLE);

  // ==========================================================================
  // Sequencer
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff + CNT_W'(1);
    nxt_pins   = pins_ff;
    nxt_dout   = dout_ff;
    nxt_doe    = doe_ff;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = 1'b0;
    nxt_init   = init_ff;
    unique case (state_ff)
      ST_INIT:
      begin
        // Power-up wait
        // Pins stay deselected while the supply settles
        if (cnt_ff == INIT_LAST)
        begin
          nxt_state = ST_IDLE;
          nxt_init  = 1'b1;
          nxt_cnt   = '0;
        end
      end
      ST_IDLE:
      begin
        nxt_cnt = '0;
        if (take && i_req.wr)
        begin
          nxt_pins.chip_sel_n          = 1'b0;
          nxt_pins.wr_strobe_n         = 1'b0;
          nxt_pins.out_en_n            = 1'b1;
          nxt_pins.lower_lane_strobe_n = ~i_req.lane_en[0];
          nxt_pins.upper_lane_strobe_n = ~i_req.lane_en[1];
          nxt_pins.word_address        = i_req.word_address;
          nxt_dout  = i_req.wdata;
          nxt_doe   = 1'b1;
          nxt_state = ST_WR_LOW;
        end
        else if (take)
        begin
          nxt_pins.chip_sel_n          = 1'b0;
          nxt_pins.out_en_n            = 1'b0;
          nxt_pins.wr_strobe_n         = 1'b1;
          nxt_pins.lower_lane_strobe_n = ~i_req.lane_en[0];
          nxt_pins.upper_lane_strobe_n = ~i_req.lane_en[1];
          nxt_pins.word_address        = i_req.word_address;
          nxt_doe   = 1'b0;
          nxt_state = ST_RD;
        end
      end
      ST_WR_LOW:
      begin
        if (cnt_ff == WR_LOW_LAST)
        begin
          nxt_pins.chip_sel_n          = 1'b1;
          nxt_pins.wr_strobe_n         = 1'b1;
          nxt_pins.lower_lane_strobe_n = 1'b1;
          nxt_pins.upper_lane_strobe_n = 1'b1;
          nxt_cnt   = '0;
          nxt_state = ST_WR_REC;
        end
      end
      ST_WR_REC:
      begin
        // Rest of the cycle time
        // Data stays driven a little past the edge for margin
        if (cnt_ff == WR_REC_LAST)
        begin
          nxt_doe   = 1'b0;
          nxt_cnt   = '0;
          nxt_state = ST_IDLE;
        end
      end
      ST_RD:
      begin
        if (cnt_ff == RD_LAST)
        begin
          nxt_rdata  = data_sync;
          nxt_rvalid = 1'b1;
          nxt_pins.chip_sel_n          = 1'b1;
          nxt_pins.out_en_n            = 1'b1;
          nxt_pins.lower_lane_strobe_n = 1'b1;
          nxt_pins.upper_lane_strobe_n = 1'b1;
          nxt_cnt   = '0;
          nxt_state = ST_TURN;
        end
      end
      ST_TURN:
      begin
        if (cnt_ff == TURN_LAST)
        begin
          nxt_cnt   = '0;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_pins  = PINS_IDLE;
        nxt_doe   = 1'b0;
        nxt_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_ff  <= ST_INIT;
      cnt_ff    <= '0;
      pins_ff   <= PINS_IDLE;
      dout_ff   <= '0;
      doe_ff    <= 1'b0;
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
      init_ff   <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      pins_ff   <= nxt_pins;
      dout_ff   <= nxt_dout;
      doe_ff    <= nxt_doe;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      init_ff   <= nxt_init;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_req_ready = (state_ff == ST_IDLE);
  assign o_rsp_valid = rvalid_ff;
  assign o_rsp_data  = rdata_ff;
  assign o_init_done = init_ff;
  assign o_pins      = pins_ff;
  assign o_data_out  = dout_ff;
  assign o_data_oe   = doe_ff;

endmodule

// ==== shared/sram_ctrl_pkg.sv ====
package sram_ctrl_pkg;

  // ==========================================================================
  // Geometry
  localparam int ADDR_W      = 15;
  localparam int DATA_W      = 16;
  localparam int LANE_W      = 8;
  localparam int LANES       = 2;
  localparam int WORDS       = 32768;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W       = 16;

  // ==========================================================================
  // Timing, figures as printed
  localparam int CLK_PERIOD_PS = 4000;
  localparam int T_POWER_US    = 100;
  localparam int T_RC_NS       = 10;
  localparam int T_ADDR_ACC_NS = 10;
  localparam int T_WC_NS       = 10;
  localparam int T_SCE_NS      = 8;
  localparam int T_AW_NS       = 8;
  localparam int T_PWE_NS      = 7;
  localparam int T_BW_NS       = 7;
  localparam int T_SD_NS       = 5;
  localparam int T_HZOE_NS     = 5;
  localparam int T_HZCE_NS     = 5;
  localparam int T_HZBE_NS     = 5;

  // Least time in ns rounded up to whole clock cycles, never below one
  function automatic int min_cycles(input int t_ns);
    int c;
    c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int POWER_UP_CYC = (T_POWER_US * 1000 * 1000) / CLK_PERIOD_PS;
  localparam int ACC_CYC      = max2(min_cycles(T_ADDR_ACC_NS), min_cycles(T_RC_NS));
  localparam int WR_LOW_CYC   = max2(max2(min_cycles(T_PWE_NS), min_cycles(T_BW_NS)),
                                     max2(max2(min_cycles(T_SCE_NS), min_cycles(T_AW_NS)),
                                          min_cycles(T_SD_NS)));
  localparam int WR_REC_CYC   = max2(min_cycles(T_WC_NS) - WR_LOW_CYC, 1);
  localparam int TURN_CYC     = max2(max2(min_cycles(T_HZOE_NS), min_cycles(T_HZCE_NS)),
                                     min_cycles(T_HZBE_NS));
  // Pin valid at the ACC_CYC edge, then two sync flops before capture
  localparam int RD_WAIT_CYC  = ACC_CYC + SYNC_STAGES;

  localparam logic [CNT_W-1:0] WR_LOW_LAST = CNT_W'(WR_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] WR_REC_LAST = CNT_W'(WR_REC_CYC - 1);
  localparam logic [CNT_W-1:0] TURN_LAST   = CNT_W'(TURN_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LAST     = CNT_W'(RD_WAIT_CYC - 1);

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] word_address;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0]  lane_en;   // [0] lower byte, [1] upper byte
  } req_s;

  typedef struct packed {
    logic              chip_sel_n;
    logic              out_en_n;
    logic              wr_strobe_n;
    logic              lower_lane_strobe_n;
    logic              upper_lane_strobe_n;
    logic [ADDR_W-1:0] word_address;
  } pins_s;

  localparam pins_s PINS_IDLE = '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_strobe_n: 1'b1,
                                  lower_lane_strobe_n: 1'b1, upper_lane_strobe_n: 1'b1,
                                  word_address: '0};

  typedef enum logic [5:0] {
    ST_INIT   = 6'h01,
    ST_IDLE   = 6'h02,
    ST_WR_LOW = 6'h04,
    ST_WR_REC = 6'h08,
    ST_RD     = 6'h10,
    ST_TURN   = 6'h20
  } state_e;

endpackage

// ==== core/sram_data_sync.sv ====
`timescale 1ns/1ps
module sram_data_sync
  import sram_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // Data
  input  wire logic [DATA_W-1:0] i_async,
  output logic      [DATA_W-1:0] o_sync
);

  // ==========================================================================
  // Two-stage capture of the data pins
  logic [DATA_W-1:0] meta_ff;
  logic [DATA_W-1:0] sync_ff;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule

// ==== verif/sram_host_ctrl_chk.sv ====
`timescale 1ns/1ps
module sram_host_ctrl_chk
  import sram_ctrl_pkg::*;
#(
  parameter int POWER_UP_CYCLES = 4
)
(
  input wire logic              i_clk,
  input wire logic              i_sys_rst,
  input wire logic              i_req_valid,
  input wire req_s              i_req,
  input wire logic              o_req_ready,
  input wire logic              o_rsp_valid,
  input wire logic [DATA_W-1:0] o_rsp_data,
  input wire logic              o_init_done,
  input wire pins_s             o_pins,
  input wire logic [DATA_W-1:0] i_data_in,
  input wire logic [DATA_W-1:0] o_data_out,
  input wire logic              o_data_oe
);
  logic tk_wr;
  logic tk_rd;
  assign tk_wr = i_req_valid && o_req_ready && i_req.wr;
  assign tk_rd = i_req_valid && o_req_ready && !i_req.wr;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========================================
  // Pin sequencing
  wr_pins_a: assert property (tk_wr |=> !o_pins.chip_sel_n && o_pins.out_en_n && o_data_oe)
    else $error("write pins wrong");
  rd_pins_a: assert property (tk_rd |=> !o_pins.out_en_n && o_pins.wr_strobe_n && !o_data_oe)
    else $error("read pins wrong");
  wr_window_a: assert property (tk_wr |=> (!o_pins.chip_sel_n && !o_pins.wr_strobe_n)[*2] ##1 o_pins.wr_strobe_n)
    else $error("write window length wrong");
  lane_map_a: assert property ((tk_wr || tk_rd) |=>
    o_pins.lower_lane_strobe_n != $past(i_req.lane_en[0]) && o_pins.upper_lane_strobe_n != $past(i_req.lane_en[1]))
    else $error("lane strobe wrong");
  rd_answer_a: assert property (tk_rd |-> !o_rsp_valid[*6] ##1 o_rsp_valid ##1 !o_rsp_valid)
    else $error("read answer timing wrong");
  bus_write_only_a: assert property (o_data_oe |-> o_pins.out_en_n)
    else $error("bus driven during read");
  addr_hold_a: assert property (!o_pins.chip_sel_n && !$past(o_pins.chip_sel_n) |-> $stable(o_pins.word_address))
    else $error("address moved in access");
  idle_desel_a: assert property (o_req_ready |-> o_pins.chip_sel_n && o_init_done)
    else $error("selected while idle");
  wr_cycle_a: assert property (tk_wr |=> !o_req_ready[*3] ##1 o_req_ready)
    else $error("write cycle length wrong");
  rd_cycle_a: assert property (tk_rd |=> !o_req_ready[*7] ##1 o_req_ready)
    else $error("read cycle length wrong");
  turn_gap_a: assert property (o_rsp_valid |-> !o_data_oe[*3])
    else $error("bus driven too soon after read");
endmodule
bind sram_host_ctrl sram_host_ctrl_chk #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
  .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_init_done(o_init_done), .o_pins(o_pins),
  .i_data_in(i_data_in), .o_data_out(o_data_out), .o_data_oe(o_data_oe));

// ==== verif/sram_dev_model.sv ====
`timescale 1ns/1ps
module sram_dev_model
  import sram_ctrl_pkg::*;
#(
  parameter int ACCESS_NS = 10
)
(
  input  wire pins_s             i_pins,
  input  wire logic [DATA_W-1:0] i_bus,
  output logic      [DATA_W-1:0] o_q
);
  // ==========================================
  // Array
  // Word array
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] rd_now;
  logic [LANES-1:0]  on_now;
  logic [LANES-1:0]  on_dly;
  logic              rd;
  logic              wl_lo;
  logic              wl_hi;
  assign wl_lo = !i_pins.chip_sel_n && !i_pins.wr_strobe_n && !i_pins.lower_lane_strobe_n;
  assign wl_hi = !i_pins.chip_sel_n && !i_pins.wr_strobe_n && !i_pins.upper_lane_strobe_n;
  always @(negedge wl_lo) mem[i_pins.word_address][7:0] = i_bus[7:0];
  always @(negedge wl_hi) mem[i_pins.word_address][15:8] = i_bus[15:8];
  assign rd = !i_pins.chip_sel_n && !i_pins.out_en_n && i_pins.wr_strobe_n;
  assign on_now = {rd && !i_pins.upper_lane_strobe_n, rd && !i_pins.lower_lane_strobe_n};
  assign #(ACCESS_NS) rd_now = mem[i_pins.word_address];
  assign #(ACCESS_NS) on_dly = on_now;
  // Off faster than on
  // A floating lane shows inverted data, so a late capture cannot pass
  assign o_q[7:0] = (on_now[0] && on_dly[0]) ? rd_now[7:0] : ~rd_now[7:0];
  assign o_q[15:8] = (on_now[1] && on_dly[1]) ? rd_now[15:8] : ~rd_now[15:8];
endmodule

// ==== verif/test_sram_host_ctrl.sv ====
`timescale 1ns/1ps
module test_sram_host_ctrl
  import sram_ctrl_pkg::*;
;
  localparam int PU = 4;
  logic              i_clk = 1'b0;
  logic              i_sys_rst = 1'b1;
  logic              i_req_valid = 1'b0;
  req_s              i_req = '0;
  logic              rdy;
  logic              rv;
  logic              oe;
  logic [DATA_W-1:0] rdat;
  logic [DATA_W-1:0] dout;
  logic [DATA_W-1:0] din;
  logic [DATA_W-1:0] q;
  pins_s             pins;
  logic              init;
  int                n_mismatch = 0;
  int                compares = 0;
  always #2 i_clk = ~i_clk;
  assign din = oe ? dout : q;
  sram_host_ctrl #(.POWER_UP_CYCLES(PU)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_data(rdat), .o_init_done(init), .o_pins(pins),
    .i_data_in(din), .o_data_out(dout), .o_data_oe(oe));
  sram_dev_model mem (.i_pins(pins), .i_bus(din), .o_q(q));
  task chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask
  // ==========================================
  // One access, entered at a falling edge and left at the one where ready is back
  task access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] ln);
    int k;
    int n_rv;
    i_req = '{wr: wr, word_address: a, wdata: d, lane_en: ln};
    i_req_valid = 1'b1;
    for (k = 0; k < 50 && rdy !== 1'b1; k++) @(negedge i_clk);
    chk("ready", {15'h0000, rdy}, 16'h0001);
    @(negedge i_clk);
    i_req_valid = 1'b0;
    n_rv = 0;
    // Walk on to the next ready, so a following call never raises valid while this access is still running
    for (k = 0; k < 12 && rdy !== 1'b1; k++)
    begin
      @(negedge i_clk);
      if (rv === 1'b1)
        n_rv++;
    end
    chk("answers", 16'(n_rv), {15'h0000, ~wr});
    chk("cycles", 16'(k), wr ? 16'(WR_LOW_CYC + WR_REC_CYC) : 16'(RD_WAIT_CYC + TURN_CYC));
  endtask
  task t_power;
    repeat (PU - 1) @(negedge i_clk);
    chk("early ready", {14'h0000, rdy, init}, 16'h0000);
    @(negedge i_clk);
    chk("ready", {15'h0000, rdy}, 16'h0001);
    chk("init done", {15'h0000, init}, 16'h0001);
    $display("power-up test done");
  endtask
  task t_word;
    access(1'b1, 15'h7fff, 16'hbeef, 2'h3);
    access(1'b1, 15'h0000, 16'h1357, 2'h3);
    access(1'b0, 15'h7fff, 16'h0000, 2'h3);
    chk("top word", rdat, 16'hbeef);
    access(1'b0, 15'h0000, 16'h0000, 2'h3);
    chk("bottom word", rdat, 16'h1357);
    $display("word test done");
  endtask
  task t_lanes;
    access(1'b1, 15'h0005, 16'h1122, 2'h3);
    access(1'b1, 15'h0005, 16'haabb, 2'h1);
    access(1'b1, 15'h0005, 16'hccdd, 2'h2);
    access(1'b1, 15'h0005, 16'h9999, 2'h0);
    access(1'b0, 15'h0005, 16'h0000, 2'h3);
    chk("merged", rdat, 16'hccbb);
    access(1'b0, 15'h0005, 16'h0000, 2'h1);
    chk("lower only", {8'h00, rdat[7:0]}, 16'h00bb);
    access(1'b0, 15'h0005, 16'h0000, 2'h2);
    chk("upper only", {rdat[15:8], 8'h00}, 16'hcc00);
    $display("lane test done");
  endtask
  task t_reset;
    i_req = '{wr: 1'b1, word_address: 15'h0006, wdata: 16'h5a5a, lane_en: 2'h3};
    i_req_valid = 1'b1;
    @(negedge i_clk);
    i_req_valid = 1'b0;
    i_sys_rst = 1'b1;
    @(negedge i_clk);
    chk("idle pins", {pins.chip_sel_n, oe, rdy, 13'h0000}, 16'h8000);
    i_sys_rst = 1'b0;
    // A second release must restart the whole power-up wait
    t_power();
    access(1'b0, 15'h0005, 16'h0000, 2'h3);
    chk("kept word", rdat, 16'hccbb);
    $display("reset test done");
  endtask
  task complete_run;
    $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(negedge i_clk);
    i_sys_rst = 1'b0;
    t_power();
    t_word();
    t_lanes();
    t_reset();
    complete_run();
  end
endmodule
